/* File: attn_responder.sv */
// Behaviour
// [R1] eight request lines, separate from the transfer handshake
// [R2] a request is a held level, pending while asserted
// [R3] any board may drive or watch any line; lines are shared
// [R4] line zero has highest priority, seven lowest
// [R5] suggested: interrupts on lines 3..0, DMA on lines 7..4
// [R6] requests can be disabled or remapped; responder can mask inputs
// [R7] implicit response: master finds and acknowledges requester by transfers
// [R8] vector fetch drives the answered line index on the address lines
// [R9] vector fetch command code is 011
// [R10] address, then address strobe, command, then data strobe
// [R11] requester decodes the index and drives its vector on data
// [R12] requester asserts data acknowledge once the vector is settled
// [R13] on acknowledge master latches vector and releases both strobes
// [R14] requester drops data and acknowledge when a strobe is released
// [R15] a longer vector comes as several data handshakes in one burst
// [R16] vector boards also answer implicit responses with the same data
// [R17] a vector-fetch master also supports implicit response
// [R18] local action: receiver acts on a request without acknowledging
// [R19] boards work with no request ever driven; no synchronous misuse
// [R20] vector fetch follows read timing; only three address lines count
// [R21] responder ignores data strobe while address strobe is released
// [R22] request lines and handshake inputs pass two-stage synchronisers
// [R23] lowest-index unmasked asserted line is chosen and encoded
`include "attn_defines.svh"
`default_nettype none
module attn_responder (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // request lines, open drain
  input  wire logic [7:0] ATNRQ_N_I,
  output logic      [7:0] ATNRQ_N_O,
  output logic      [7:0] ATNRQ_OE,
  // transfer handshake
  output logic      [2:0] A,
  output logic      [2:0] CM,
  output logic            ADRSTB_N,
  output logic            DATSTB_N,
  input  wire logic [7:0] D,
  input  wire logic       DATAACK_N,
  input  wire logic       TFRERR_N,
  // user control
  input  wire logic [7:0] RAISE,
  input  wire logic [7:0] MASK,
  input  wire logic       START,
  input  wire logic [1:0] EXTRA_BYTES,
  // user status
  output logic            BUSY,
  output logic            PENDING,
  output logic      [2:0] PEND_LINE,
  output logic      [7:0] LOCAL_ACT,
  output logic            VEC_VALID,
  output logic      [7:0] VEC_DATA,
  output logic      [2:0] VEC_LINE,
  output logic            XFER_ERR
);
  localparam logic [1:0] TIS = 2'(`ATTN_TIS_CYC);

  function automatic logic [3:0] pick(input logic [7:0] r);
    logic [3:0] res;
    res = 4'h0;
    for (int i = `ATTN_LINES - 1; i >= 0; i--) begin
      if (r[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : pick

  // setup wait ends on the last count
  function automatic logic setup_done(input logic [1:0] c);
    return c <= 2'h1;
  endfunction : setup_done

  // synchronisers
  logic [7:0] rq_m_q, rq_s_q;
  logic       ack_m_q, ack_s_q, err_m_q, err_s_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      rq_m_q  <= 8'hff;
      rq_s_q  <= 8'hff;
      ack_m_q <= 1'b1;
      ack_s_q <= 1'b1;
      err_m_q <= 1'b1;
      err_s_q <= 1'b1;
    end else begin
      rq_m_q  <= ATNRQ_N_I; // see [R22]
      rq_s_q  <= rq_m_q;
      ack_m_q <= DATAACK_N;
      ack_s_q <= ack_m_q;
      err_m_q <= TFRERR_N;
      err_s_q <= err_m_q;
    end
  end

  logic [7:0] req_lvl; // see [R1]
  logic [3:0] sel;
  logic       ack, err;
  assign req_lvl = ~rq_s_q & ~MASK; // see [R2] see [R6]
  assign sel     = pick(req_lvl);   // see [R4] see [R5] see [R23]
  assign ack     = ~ack_s_q;
  assign err     = ~err_s_q;

  // own requests, open drain onto shared lines
  logic [7:0] raise_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      raise_q <= 8'h00;
    end else begin
      raise_q <= RAISE; // see [R3]
    end
  end
  assign ATNRQ_N_O = 8'h00;
  assign ATNRQ_OE  = raise_q;

  // status seen by the user for implicit and local responses
  logic [7:0] local_q;
  logic [3:0] pend_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      local_q <= 8'h00;
      pend_q  <= 4'h0;
    end else begin
      local_q <= req_lvl; // see [R18]
      pend_q  <= sel;     // see [R7] see [R17]
    end
  end
  assign LOCAL_ACT = local_q;
  assign PENDING   = pend_q[3]; // see [R16]
  assign PEND_LINE = pend_q[2:0];

  // vector fetch sequencer
  attn_pkg::state_e   st_q, st_d;
  attn_pkg::bus_out_s bus_q, bus_d;
  logic [1:0] cnt_q, cnt_d, left_q, left_d;
  logic [2:0] line_q, line_d;
  logic [7:0] vec_q, vec_d;
  logic       vval_q, vval_d, err_q, err_d;

  always_comb begin
    st_d   = st_q;
    bus_d  = bus_q;
    cnt_d  = cnt_q;
    left_d = left_q;
    line_d = line_q;
    vec_d  = vec_q;
    vval_d = 1'b0;
    err_d  = 1'b0;
    case (st_q)
      attn_pkg::S_IDLE: begin
        if (START && sel[3] && !ack && !err) begin // see [R19]
          line_d     = sel[2:0];
          bus_d.adr  = sel[2:0];          // see [R8] see [R20]
          bus_d.cm   = `ATTN_CM_VFETCH;   // see [R9]
          cnt_d      = TIS;
          left_d     = EXTRA_BYTES;
          st_d       = attn_pkg::S_ADDR;
        end
      end
      attn_pkg::S_ADDR: begin
        if (!setup_done(cnt_q)) begin
          cnt_d = cnt_q - 2'h1;
        end else begin
          bus_d.adrstb_n = 1'b0;          // see [R10]
          cnt_d          = TIS;
          st_d           = attn_pkg::S_ASTB;
        end
      end
      attn_pkg::S_ASTB: begin
        if (!setup_done(cnt_q)) begin
          cnt_d = cnt_q - 2'h1;
        end else begin
          bus_d.datstb_n = 1'b0;          // see [R10]
          st_d           = attn_pkg::S_DSTB;
        end
      end
      attn_pkg::S_DSTB: begin
        if (err) begin
          bus_d.adrstb_n = 1'b1;
          bus_d.datstb_n = 1'b1;
          err_d          = 1'b1;
          st_d           = attn_pkg::S_END;
        end else if (ack) begin           // see [R12]
          vec_d  = D;                     // see [R11] see [R13]
          vval_d = 1'b1;
          bus_d.datstb_n = 1'b1;
          if (left_q != 2'h0) begin
            left_d = left_q - 2'h1;       // see [R15]
            st_d   = attn_pkg::S_DREL;
          end else begin
            bus_d.adrstb_n = 1'b1;        // see [R13]
            st_d           = attn_pkg::S_END;
          end
        end
      end
      attn_pkg::S_DREL: begin
        if (!ack && !err) begin // see [R14]
          cnt_d = TIS;
          st_d  = attn_pkg::S_ASTB;
        end
      end
      attn_pkg::S_END: begin
        if (!ack && !err) begin // see [R14]
          bus_d.adr = `ATTN_ADR_IDLE;
          bus_d.cm  = `ATTN_CM_IDLE;
          st_d      = attn_pkg::S_IDLE;
        end
      end
      default: begin
        st_d = attn_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q   <= attn_pkg::S_IDLE;
      bus_q  <= '{adr: `ATTN_ADR_IDLE, cm: `ATTN_CM_IDLE, adrstb_n: 1'b1, datstb_n: 1'b1};
      cnt_q  <= 2'h0;
      left_q <= 2'h0;
      line_q <= 3'h0;
      vec_q  <= 8'h00;
      vval_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      bus_q  <= bus_d;
      cnt_q  <= cnt_d;
      left_q <= left_d;
      line_q <= line_d;
      vec_q  <= vec_d;
      vval_q <= vval_d;
      err_q  <= err_d;
    end
  end

  assign A         = bus_q.adr;
  assign CM        = bus_q.cm;
  assign ADRSTB_N  = bus_q.adrstb_n;
  assign DATSTB_N  = bus_q.datstb_n;
  assign BUSY      = (st_q != attn_pkg::S_IDLE);
  assign VEC_VALID = vval_q;
  assign VEC_DATA  = vec_q;
  assign VEC_LINE  = line_q;
  assign XFER_ERR  = err_q;

  // checks
  chk_dstb_needs_astb: assert property (@(posedge CLK) disable iff (RST) // see [R21]
    !DATSTB_N |-> !ADRSTB_N) else $error("data strobe without address strobe");
  chk_cmd_is_vfetch: assert property (@(posedge CLK) disable iff (RST) // see [R9]
    !ADRSTB_N |-> CM == `ATTN_CM_VFETCH) else $error("wrong command code");
  chk_adr_setup: assert property (@(posedge CLK) disable iff (RST) // see [R10]
    $fell(ADRSTB_N) |-> $past(A) == A && $past(A, 2) == A) else $error("address setup too short");
  chk_cmd_setup: assert property (@(posedge CLK) disable iff (RST) // see [R10]
    $fell(DATSTB_N) |-> $past(ADRSTB_N, 2) == 1'b0) else $error("command setup too short");
  chk_adr_stable: assert property (@(posedge CLK) disable iff (RST) // see [R20]
    !ADRSTB_N && !$past(ADRSTB_N) |-> $stable(A)) else $error("address moved under strobe");
  chk_ack_release: assert property (@(posedge CLK) disable iff (RST) // see [R13]
    st_q == attn_pkg::S_DSTB && ack && left_q == 2'h0 && !err
    |=> ADRSTB_N && DATSTB_N && VEC_VALID && VEC_DATA == $past(D)) else $error("no release on ack");
  chk_burst_keep: assert property (@(posedge CLK) disable iff (RST) // see [R15]
    st_q == attn_pkg::S_DSTB && ack && left_q != 2'h0 && !err
    |=> !ADRSTB_N && DATSTB_N) else $error("burst dropped address strobe");
  chk_line_priority: assert property (@(posedge CLK) disable iff (RST) // see [R4]
    $rose(BUSY) |-> ($past(req_lvl) & ((8'h01 << A) - 8'h01)) == 8'h00
      && ($past(req_lvl) & (8'h01 << A)) != 8'h00)
    else $error("not lowest pending line");
  chk_line_encode: assert property (@(posedge CLK) disable iff (RST) // see [R8]
    !ADRSTB_N |-> A == VEC_LINE) else $error("address not the answered line");
  chk_err_end: assert property (@(posedge CLK) disable iff (RST)
    st_q == attn_pkg::S_DSTB && err |=> ADRSTB_N ##0 XFER_ERR) else $error("error not ended");
  cov_single: cover property (@(posedge CLK) disable iff (RST) VEC_VALID && !BUSY ##0 $past(BUSY));
  cov_burst: cover property (@(posedge CLK) disable iff (RST) st_q == attn_pkg::S_DREL);
  cov_err: cover property (@(posedge CLK) disable iff (RST) XFER_ERR);
  cov_masked: cover property (@(posedge CLK) disable iff (RST) $rose(BUSY) && $past(MASK) != 8'h00);
  cov_refused: cover property (@(posedge CLK) disable iff (RST) START && !BUSY && !sel[3]);
  chk_mask_honoured: assert property (@(posedge CLK) disable iff (RST) // see [R6]
    $rose(BUSY) |-> ($past(MASK) & (8'h01 << A)) == 8'h00)
    else $error("masked line answered");
  chk_sync_stages: assert property (@(posedge CLK) disable iff (RST) // see [R22]
    $rose(BUSY) |-> (~$past(ATNRQ_N_I, 3) & (8'h01 << A)) != 8'h00)
    else $error("request used before synchronised");
  chk_start_gated: assert property (@(posedge CLK) disable iff (RST) // see [R19]
    $rose(BUSY) |-> $past(START) && $past(sel[3]))
    else $error("fetch without start or pending line");
  chk_idle_quiet: assert property (@(posedge CLK) disable iff (RST) // see [R19]
    !BUSY |-> ADRSTB_N && DATSTB_N && CM == `ATTN_CM_IDLE)
    else $error("bus not quiet while idle");
  chk_ack_wait: assert property (@(posedge CLK) disable iff (RST) // see [R14]
    st_q == attn_pkg::S_END && (ack || err) |=> BUSY && ADRSTB_N && DATSTB_N)
    else $error("sequence ended before acknowledge released");
  chk_vec_hold: assert property (@(posedge CLK) disable iff (RST) // see [R13]
    !VEC_VALID |-> $stable(VEC_DATA))
    else $error("vector changed without valid");
  chk_vec_pulse: assert property (@(posedge CLK) disable iff (RST) // see [R15]
    VEC_VALID |=> !VEC_VALID)
    else $error("vector valid longer than one cycle");
  chk_err_pulse: assert property (@(posedge CLK) disable iff (RST)
    XFER_ERR |=> !XFER_ERR)
    else $error("error flag longer than one cycle");
endmodule : attn_responder
`default_nettype wire

/* File: attn_defines.svh */
`ifndef ATTN_DEFINES_SVH
`define ATTN_DEFINES_SVH
`define ATTN_CLK_MHZ   40
`define ATTN_TIS_NS    35
`define ATTN_TIS_CYC   ((`ATTN_TIS_NS * `ATTN_CLK_MHZ + 999) / 1000)
`define ATTN_CM_VFETCH 3'h3
`define ATTN_CM_IDLE   3'h0
`define ATTN_ADR_IDLE  3'h0
`define ATTN_LINES     8
`endif

/* File: attn_pkg.sv */
`default_nettype none
package attn_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ASTB, S_DSTB, S_DREL, S_END} state_e;
  typedef struct packed {
    logic [2:0] adr;
    logic [2:0] cm;
    logic       adrstb_n;
    logic       datstb_n;
  } bus_out_s;
endpackage : attn_pkg
`default_nettype wire

/* File: attn_board_model.sv */
`default_nettype none
module attn_board_model (
  // bench control
  input  wire logic       CLK,
  input  wire logic [7:0] RQ_SET,
  input  wire logic [3:0] DLY,
  input  wire logic       ERR,
  // bus side
  input  wire logic [2:0] A,
  input  wire logic [2:0] CM,
  input  wire logic       ADRSTB_N,
  input  wire logic       DATSTB_N,
  output logic      [7:0] ATNRQ_N,
  output logic      [7:0] D,
  output logic            DATAACK_N,
  output logic            TFRERR_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pend = 8'h00;
  logic [7:0] set_q = 8'h00;
  logic [3:0] cnt  = 4'h0;
  logic [1:0] nb   = 2'h0;
  logic       got  = 1'b0;
  initial begin
    D = 8'h00;
    DATAACK_N = 1'b1;
    TFRERR_N = 1'b1;
  end
  assign ATNRQ_N = ~pend;
  // posted requests taken at the edge, clear of the bench's next change
  always @(posedge CLK) set_q <= RQ_SET;
  always @(posedge CLK) begin
    #1;
    pend = pend | set_q;
    if (!DATAACK_N || !TFRERR_N) begin
      if (ADRSTB_N || DATSTB_N) begin
        D = ~D;
        got = got | !DATAACK_N;
        DATAACK_N = 1'b1;
        TFRERR_N = 1'b1;
        nb = nb + 2'h1;
      end
    end else if (!ADRSTB_N && !DATSTB_N && CM == 3'h3 && pend[A]) begin
      D = {nb, 3'h5, A};
      if (cnt <= DLY) begin
        cnt = cnt + 4'h1;
      end else begin
        cnt = 4'h0;
        if (ERR) TFRERR_N = 1'b0;
        else DATAACK_N = 1'b0;
      end
    end
    if (ADRSTB_N) begin
      if (got) pend[A] = 1'b0;
      got = 1'b0;
      nb = 2'h0;
    end
  end
endmodule : attn_board_model
`default_nettype wire

/* File: attention_request_vector_fetch_bench.sv */
`default_nettype none
module attention_request_vector_fetch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, err = 1'b0, adrstb_n, datstb_n, ack_n, tfr_n;
  logic busy, pending, vec_valid, xfer_err;
  logic [7:0] raise = 8'h00, mask = 8'h00, rq_set = 8'h00, pend_e = 8'h00, brd_n, d, oe, local_act, vec_data;
  logic [1:0] xb = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [2:0] a, cm, pend_line, vec_line;
  logic [7:0] n_o;
  logic [11:0] exp_q[$];
  logic [11:0] ex;
  logic [31:0] seed = 32'h0000_883d;
  int miscompares = 0, n_compared = 0, cycles = 0;
  attn_responder dut (.CLK(clk), .RST(rst), .ATNRQ_N_I(brd_n & ~(oe & ~n_o)), .ATNRQ_N_O(n_o), .ATNRQ_OE(oe),
    .A(a), .CM(cm), .ADRSTB_N(adrstb_n), .DATSTB_N(datstb_n), .D(d), .DATAACK_N(ack_n), .TFRERR_N(tfr_n),
    .RAISE(raise), .MASK(mask), .START(start), .EXTRA_BYTES(xb), .BUSY(busy), .PENDING(pending),
    .PEND_LINE(pend_line), .LOCAL_ACT(local_act), .VEC_VALID(vec_valid), .VEC_DATA(vec_data),
    .VEC_LINE(vec_line), .XFER_ERR(xfer_err));
  attn_board_model brd (.CLK(clk), .RQ_SET(rq_set), .DLY(dly), .ERR(err), .A(a), .CM(cm),
    .ADRSTB_N(adrstb_n), .DATSTB_N(datstb_n), .ATNRQ_N(brd_n), .D(d), .DATAACK_N(ack_n), .TFRERR_N(tfr_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [2:0] low(input logic [7:0] v);
    low = 3'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) low = i[2:0];
  endfunction : low
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic post(input logic [7:0] r);
    rq_set = r;
    tick(1);
    rq_set = 8'h00;
    pend_e |= r;
  endtask : post
  task automatic fetch(input logic [7:0] m, input logic e);
    logic [2:0] ln;
    logic       hit;
    int k;
    mask = m;
    err = e;
    xb = e ? 2'h0 : seed[1:0];
    dly = {1'b0, seed[4:2]};
    tick(4);
    ln = low(pend_e & ~m);
    hit = |(pend_e & ~m);
    chk("pending", pending, hit);
    chk("pend_line", pend_line, ln);
    chk("local_act", local_act, pend_e & ~m);
    for (k = 0; k <= xb && hit; k++) exp_q.push_back({e, ln, e ? 8'h00 : {k[1:0], 3'h5, ln}});
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 20 && datstb_n !== 1'b0 && hit; k++) tick(1);
    if (hit) begin
      chk("addr", a, ln);
      chk("cmd", cm, 3'h3);
      chk("adrstb", adrstb_n, 1'b0);
      chk("datstb", datstb_n, 1'b0);
    end else chk("refused", busy, 1'b0);
    for (k = 0; k < 300 && busy !== 1'b0; k++) tick(1);
    chk("busy_end", busy, 1'b0);
    chk("queue", 8'(exp_q.size()), 8'h00);
    if (hit && !e) pend_e[ln] = 1'b0;
  endtask : fetch
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  always @(posedge clk) begin
    #2;
    if (vec_valid === 1'b1 || xfer_err === 1'b1) begin
      ex = exp_q.size() > 0 ? exp_q.pop_front() : 12'hfff;
      chk("xfer_err", xfer_err, ex[11]);
      if (!ex[11]) chk("vec_line", vec_line, ex[10:8]);
      if (!ex[11]) chk("vec_data", vec_data, ex[7:0]);
    end
  end
  initial begin
    tick(2);
    rst = 1'b0;
    tick(3);
    chk("idle", {busy, adrstb_n, datstb_n, cm, pending}, 8'h30);
    fetch(8'h00, 1'b0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      post(seed[15:8]);
      fetch(seed[23:16] & seed[31:24], 1'b0);
    end
    post(8'h80);
    fetch(8'h00, 1'b1);
    for (int i = 0; i < 9; i++) fetch(8'h00, 1'b0);
    raise = seed[7:0] | 8'h01;
    tick(4);
    chk("raise_oe", oe, raise);
    chk("raise_lvl", n_o, 8'h00);
    chk("own_req", local_act, raise | pend_e);
    raise = 8'h00;
    tick(4);
    print_verdict;
  end
endmodule : attention_request_vector_fetch_bench
`default_nettype wire
